/* File: common/bfifo_pkg.sv */
// Purpose: shared constants and parity helpers for the two-queue port block
// Assumes: 36-bit words made of four nine-bit bytes, parity bit on top
// Notes: flag indices address the packed synchroniser vector in the top
`default_nettype none
package bfifo_pkg;
    localparam int DATA_W = 36;
    localparam int BYTE_W = 9;
    localparam int BYTES = 4;
    localparam int DEPTH = 64;
    localparam int PTR_W = 6;
    localparam int CNT_W = 7;
    localparam int ALMOST_OFFSET = 8;
    localparam int FLAGS = 8;
    localparam logic [CNT_W-1:0] CNT_FULL = 7'h40;
    localparam logic [CNT_W-1:0] CNT_RESET = 7'h00;
    localparam logic [PTR_W-1:0] PTR_RESET = 6'h00;
    localparam logic [1:0] SYNC_RESET = 2'h0;
    localparam logic MAIL_FREE_RESET = 1'b1;
    localparam logic [DATA_W-1:0] WORD_RESET = 36'h000000000;
    // synchroniser slots: reader-side empty/almost-empty, writer-side full/almost-full
    localparam int F_EMPTY_A = 0;
    localparam int F_AEMPTY_A = 1;
    localparam int F_FULL_A = 2;
    localparam int F_AFULL_A = 3;
    localparam int F_EMPTY_B = 4;
    localparam int F_AEMPTY_B = 5;
    localparam int F_FULL_B = 6;
    localparam int F_AFULL_B = 7;

    // generated top bit per byte: count of ones over nine bits follows the sense
    function automatic logic [BYTES-1:0] byte_parity(input logic [DATA_W-1:0] d,
                                                     input logic odd);
        logic [BYTES-1:0] p;
        p = '0;
        for (int i = 0; i < BYTES; i++) begin
            p[i] = (^d[i*BYTE_W +: BYTE_W-1]) ^ odd;
        end
        return p;
    endfunction : byte_parity

    function automatic logic [DATA_W-1:0] put_parity(input logic [DATA_W-1:0] d,
                                                     input logic [BYTES-1:0] p);
        logic [DATA_W-1:0] r;
        r = d;
        for (int i = 0; i < BYTES; i++) begin
            r[i*BYTE_W+BYTE_W-1] = p[i];
        end
        return r;
    endfunction : put_parity

    function automatic logic [BYTES-1:0] byte_errors(input logic [DATA_W-1:0] d,
                                                     input logic odd);
        logic [BYTES-1:0] e;
        e = '0;
        for (int i = 0; i < BYTES; i++) begin
            e[i] = (^d[i*BYTE_W +: BYTE_W]) ^ odd;
        end
        return e;
    endfunction : byte_errors
endpackage : bfifo_pkg
`default_nettype wire

/* File: hdl/parity_tree.sv */
// Purpose: four byte parity trees of one port, checking or generating
// Assumes: caller picks the word fed in (bus input or a mailbox word)
// Notes: purely combinational; the caller registers its results
`default_nettype none
module parity_tree
    import bfifo_pkg::*;
(
    input wire logic [bfifo_pkg::DATA_W-1:0] data,
    input wire logic odd,
    output logic [bfifo_pkg::BYTES-1:0] gen_bits,
    output logic any_error
);
    assign gen_bits = byte_parity(data, odd);
    assign any_error = |byte_errors(data, odd);
endmodule : parity_tree
`default_nettype wire

/* File: hdl/bidir_fifo_port.sv */
// Purpose: two opposite queues, two mailboxes, read parity generation, flag sync
// Assumes: port clocks arrive as one-cycle tick inputs sampled by CORE_CLK
// Notes: offset register loading at reset is replaced by a fixed parameter
// Operation
// - generated reads replace each byte top bit with computed parity
// - queue parity is computed between array and output register
// - parity selects sampled only on the tick loading a new queue word
// - a-to-b mailbox parity uses port-B trees, b-to-a uses port-A trees
// - trees generate mailbox parity only for enabled chip-selected mailbox reads
// - mailbox contents never change from a generated read
// - port-B empty flag rises next B cycle after write, or one later
// - port-A empty flag rises next A cycle after write, or one later
// - port-A full flag rises next A cycle after B read, or one later
// - port-B full flag rises next B cycle after A read, or one later
// - almost-empty rises next reader cycle after threshold write, or one later
// - almost-full rises next writer cycle after threshold read, or one later
// - lower eight bits of each nine-bit byte feed its parity
// - almost-empty rises only after two synchronising ticks, and falls at once
`default_nettype none
module bidir_fifo_port
    import bfifo_pkg::*;
#(
    parameter int X_OFFSET = ALMOST_OFFSET
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic CE,
    input wire logic PORT_A_CLOCK,
    input wire logic PORT_A_CHIP_SELECT_N,
    input wire logic PORT_A_WRITE_READ_SEL,
    input wire logic PORT_A_MAILBOX_SEL,
    input wire logic PORT_A_ENABLE,
    input wire logic PORT_A_PARITY_GEN_SEL,
    input wire logic [bfifo_pkg::DATA_W-1:0] PORT_A_BUS_IN,
    output logic [bfifo_pkg::DATA_W-1:0] PORT_A_BUS_OUT,
    output logic PORT_A_BUS_OE_N,
    input wire logic PORT_B_CLOCK,
    input wire logic PORT_B_CHIP_SELECT_N,
    input wire logic PORT_B_WRITE_READ_SEL,
    input wire logic PORT_B_MAILBOX_SEL,
    input wire logic PORT_B_ENABLE,
    input wire logic PORT_B_PARITY_GEN_SEL,
    input wire logic [bfifo_pkg::DATA_W-1:0] PORT_B_BUS_IN,
    output logic [bfifo_pkg::DATA_W-1:0] PORT_B_BUS_OUT,
    output logic PORT_B_BUS_OE_N,
    input wire logic PARITY_ODD_SEL,
    output logic PORT_A_EMPTY_N,
    output logic PORT_A_ALMOST_EMPTY_N,
    output logic PORT_A_FULL_N,
    output logic PORT_A_ALMOST_FULL_N,
    output logic PORT_B_EMPTY_N,
    output logic PORT_B_ALMOST_EMPTY_N,
    output logic PORT_B_FULL_N,
    output logic PORT_B_ALMOST_FULL_N,
    output logic PORT_A_PARITY_ERROR_N,
    output logic PORT_B_PARITY_ERROR_N,
    output logic A_TO_B_MAILBOX_FREE,
    output logic B_TO_A_MAILBOX_FREE
);
    import bfifo_pkg::*;

    localparam logic [CNT_W-1:0] X_CNT = CNT_W'(X_OFFSET);
    localparam logic [CNT_W-1:0] AF_CNT = CNT_W'(DEPTH - X_OFFSET);

    logic [DATA_W-1:0] a_to_b_queue [DEPTH];
    logic [DATA_W-1:0] b_to_a_queue [DEPTH];

    logic [PTR_W-1:0] wp_ab_ff, rp_ab_ff, wp_ba_ff, rp_ba_ff;
    logic [PTR_W-1:0] nxt_wp_ab, nxt_rp_ab, nxt_wp_ba, nxt_rp_ba;
    logic [CNT_W-1:0] cnt_ab_ff, cnt_ba_ff, nxt_cnt_ab, nxt_cnt_ba;
    logic [FLAGS-1:0][1:0] sync_ff, nxt_sync;
    logic [DATA_W-1:0] a_to_b_mailbox_ff, b_to_a_mailbox_ff;
    logic [DATA_W-1:0] nxt_mbox_ab, nxt_mbox_ba;
    logic mfree_ab_ff, mfree_ba_ff, nxt_mfree_ab, nxt_mfree_ba;
    logic [DATA_W-1:0] qout_a_ff, qout_b_ff, nxt_qout_a, nxt_qout_b;
    logic [DATA_W-1:0] out_a_ff, out_b_ff, nxt_out_a, nxt_out_b;
    logic oe_a_n_ff, oe_b_n_ff, pef_a_n_ff, pef_b_n_ff;
    logic nxt_oe_a_n, nxt_oe_b_n, nxt_pef_a_n, nxt_pef_b_n;

    logic tick_a, tick_b, sel_a, sel_b;
    logic wr_ab, rd_ab, wr_ba, rd_ba;
    logic mwr_ab, mrd_ab, mwr_ba, mrd_ba;
    logic mgen_a, mgen_b;
    logic [DATA_W-1:0] tree_a_in, tree_b_in;
    logic [BYTES-1:0] tree_a_bits, tree_b_bits;
    logic tree_a_err, tree_b_err;

    // {first stage, flag}: falls at once, rises only through two ticks
    function automatic logic [1:0] flag_step(input logic [1:0] cur, input logic tick,
                                             input logic cond_now, input logic cond_nxt);
        if (!cond_nxt) begin
            return SYNC_RESET;
        end
        if (tick) begin
            return {cond_now, cur[1]};
        end
        return cur;
    endfunction : flag_step

    assign tick_a = CE & PORT_A_CLOCK;
    assign tick_b = CE & PORT_B_CLOCK;
    assign sel_a = ~PORT_A_CHIP_SELECT_N & PORT_A_ENABLE;
    assign sel_b = ~PORT_B_CHIP_SELECT_N & PORT_B_ENABLE;
    // queue accesses are gated by the registered flags
    assign wr_ab = tick_a & sel_a & PORT_A_WRITE_READ_SEL & ~PORT_A_MAILBOX_SEL & PORT_A_FULL_N;
    assign rd_ab = tick_b & sel_b & ~PORT_B_WRITE_READ_SEL & ~PORT_B_MAILBOX_SEL & PORT_B_EMPTY_N;
    assign wr_ba = tick_b & sel_b & PORT_B_WRITE_READ_SEL & ~PORT_B_MAILBOX_SEL & PORT_B_FULL_N;
    assign rd_ba = tick_a & sel_a & ~PORT_A_WRITE_READ_SEL & ~PORT_A_MAILBOX_SEL & PORT_A_EMPTY_N;
    assign mwr_ab = tick_a & sel_a & PORT_A_WRITE_READ_SEL & PORT_A_MAILBOX_SEL;
    assign mrd_ab = tick_b & sel_b & ~PORT_B_WRITE_READ_SEL & PORT_B_MAILBOX_SEL;
    assign mwr_ba = tick_b & sel_b & PORT_B_WRITE_READ_SEL & PORT_B_MAILBOX_SEL;
    assign mrd_ba = tick_a & sel_a & ~PORT_A_WRITE_READ_SEL & PORT_A_MAILBOX_SEL;

    // level-sensitive, as the trees are combinational
    assign mgen_a = sel_a & ~PORT_A_WRITE_READ_SEL & PORT_A_MAILBOX_SEL & PORT_A_PARITY_GEN_SEL;
    assign mgen_b = sel_b & ~PORT_B_WRITE_READ_SEL & PORT_B_MAILBOX_SEL & PORT_B_PARITY_GEN_SEL;
    assign tree_a_in = mgen_a ? b_to_a_mailbox_ff : PORT_A_BUS_IN;
    assign tree_b_in = mgen_b ? a_to_b_mailbox_ff : PORT_B_BUS_IN;

    parity_tree u_tree_a (
        .data(tree_a_in),
        .odd(PARITY_ODD_SEL),
        .gen_bits(tree_a_bits),
        .any_error(tree_a_err)
    );
    parity_tree u_tree_b (
        .data(tree_b_in),
        .odd(PARITY_ODD_SEL),
        .gen_bits(tree_b_bits),
        .any_error(tree_b_err)
    );

    always_comb begin
        nxt_wp_ab = wr_ab ? wp_ab_ff + 6'h01 : wp_ab_ff;
        nxt_rp_ab = rd_ab ? rp_ab_ff + 6'h01 : rp_ab_ff;
        nxt_wp_ba = wr_ba ? wp_ba_ff + 6'h01 : wp_ba_ff;
        nxt_rp_ba = rd_ba ? rp_ba_ff + 6'h01 : rp_ba_ff;
        nxt_cnt_ab = cnt_ab_ff + CNT_W'(wr_ab) - CNT_W'(rd_ab);
        nxt_cnt_ba = cnt_ba_ff + CNT_W'(wr_ba) - CNT_W'(rd_ba);
        // a write on the same core cycle as a reader tick is seen a tick later
        nxt_sync[F_EMPTY_B] = flag_step(sync_ff[F_EMPTY_B], tick_b,
                                        cnt_ab_ff != CNT_RESET,
                                        nxt_cnt_ab != CNT_RESET);
        nxt_sync[F_EMPTY_A] = flag_step(sync_ff[F_EMPTY_A], tick_a,
                                        cnt_ba_ff != CNT_RESET,
                                        nxt_cnt_ba != CNT_RESET);
        nxt_sync[F_FULL_A] = flag_step(sync_ff[F_FULL_A], tick_a,
                                       cnt_ab_ff != CNT_FULL,
                                       nxt_cnt_ab != CNT_FULL);
        nxt_sync[F_FULL_B] = flag_step(sync_ff[F_FULL_B], tick_b,
                                       cnt_ba_ff != CNT_FULL,
                                       nxt_cnt_ba != CNT_FULL);
        nxt_sync[F_AEMPTY_B] = flag_step(sync_ff[F_AEMPTY_B], tick_b,
                                         cnt_ab_ff > X_CNT, nxt_cnt_ab > X_CNT);
        nxt_sync[F_AEMPTY_A] = flag_step(sync_ff[F_AEMPTY_A], tick_a,
                                         cnt_ba_ff > X_CNT, nxt_cnt_ba > X_CNT);
        nxt_sync[F_AFULL_A] = flag_step(sync_ff[F_AFULL_A], tick_a,
                                        cnt_ab_ff < AF_CNT, nxt_cnt_ab < AF_CNT);
        nxt_sync[F_AFULL_B] = flag_step(sync_ff[F_AFULL_B], tick_b,
                                        cnt_ba_ff < AF_CNT, nxt_cnt_ba < AF_CNT);
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            wp_ab_ff <= PTR_RESET;
            rp_ab_ff <= PTR_RESET;
            wp_ba_ff <= PTR_RESET;
            rp_ba_ff <= PTR_RESET;
            cnt_ab_ff <= CNT_RESET;
            cnt_ba_ff <= CNT_RESET;
            sync_ff <= '0;
        end else if (CE) begin
            wp_ab_ff <= nxt_wp_ab;
            rp_ab_ff <= nxt_rp_ab;
            wp_ba_ff <= nxt_wp_ba;
            rp_ba_ff <= nxt_rp_ba;
            cnt_ab_ff <= nxt_cnt_ab;
            cnt_ba_ff <= nxt_cnt_ba;
            sync_ff <= nxt_sync;
        end
    end

    // array contents need no reset; reads only follow a counted write
    always_ff @(posedge CORE_CLK) begin
        if (wr_ab) begin
            a_to_b_queue[wp_ab_ff] <= PORT_A_BUS_IN;
        end
        if (wr_ba) begin
            b_to_a_queue[wp_ba_ff] <= PORT_B_BUS_IN;
        end
    end

    always_comb begin
        nxt_mbox_ab = a_to_b_mailbox_ff;
        nxt_mbox_ba = b_to_a_mailbox_ff;
        nxt_mfree_ab = mfree_ab_ff;
        nxt_mfree_ba = mfree_ba_ff;
        // writes to an occupied mailbox are dropped
        if (mwr_ab && mfree_ab_ff) begin
            nxt_mbox_ab = PORT_A_BUS_IN;
            nxt_mfree_ab = 1'b0;
        end
        if (mrd_ab) begin
            nxt_mfree_ab = 1'b1;
        end
        if (mwr_ba && mfree_ba_ff) begin
            nxt_mbox_ba = PORT_B_BUS_IN;
            nxt_mfree_ba = 1'b0;
        end
        if (mrd_ba) begin
            nxt_mfree_ba = 1'b1;
        end
        // parity substituted on the way to the output register
        nxt_qout_a = qout_a_ff;
        nxt_qout_b = qout_b_ff;
        if (rd_ba) begin
            nxt_qout_a = b_to_a_queue[rp_ba_ff];
            if (PORT_A_PARITY_GEN_SEL) begin
                nxt_qout_a = put_parity(nxt_qout_a,
                                        byte_parity(nxt_qout_a, PARITY_ODD_SEL));
            end
        end
        if (rd_ab) begin
            nxt_qout_b = a_to_b_queue[rp_ab_ff];
            if (PORT_B_PARITY_GEN_SEL) begin
                nxt_qout_b = put_parity(nxt_qout_b,
                                        byte_parity(nxt_qout_b, PARITY_ODD_SEL));
            end
        end
        // only the driven copy carries generated bits
        nxt_out_a = nxt_qout_a;
        nxt_out_b = nxt_qout_b;
        if (PORT_A_MAILBOX_SEL) begin
            nxt_out_a = mgen_a ? put_parity(b_to_a_mailbox_ff, tree_a_bits) : b_to_a_mailbox_ff;
        end
        if (PORT_B_MAILBOX_SEL) begin
            nxt_out_b = mgen_b ? put_parity(a_to_b_mailbox_ff, tree_b_bits) : a_to_b_mailbox_ff;
        end
        nxt_oe_a_n = ~(~PORT_A_CHIP_SELECT_N & ~PORT_A_WRITE_READ_SEL);
        nxt_oe_b_n = ~(~PORT_B_CHIP_SELECT_N & ~PORT_B_WRITE_READ_SEL);
        // trees busy generating cannot report a checking error
        nxt_pef_a_n = mgen_a | ~tree_a_err;
        nxt_pef_b_n = mgen_b | ~tree_b_err;
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            a_to_b_mailbox_ff <= WORD_RESET;
            b_to_a_mailbox_ff <= WORD_RESET;
            mfree_ab_ff <= MAIL_FREE_RESET;
            mfree_ba_ff <= MAIL_FREE_RESET;
            qout_a_ff <= WORD_RESET;
            qout_b_ff <= WORD_RESET;
            out_a_ff <= WORD_RESET;
            out_b_ff <= WORD_RESET;
            oe_a_n_ff <= 1'b1;
            oe_b_n_ff <= 1'b1;
            pef_a_n_ff <= 1'b1;
            pef_b_n_ff <= 1'b1;
        end else if (CE) begin
            a_to_b_mailbox_ff <= nxt_mbox_ab;
            b_to_a_mailbox_ff <= nxt_mbox_ba;
            mfree_ab_ff <= nxt_mfree_ab;
            mfree_ba_ff <= nxt_mfree_ba;
            qout_a_ff <= nxt_qout_a;
            qout_b_ff <= nxt_qout_b;
            out_a_ff <= nxt_out_a;
            out_b_ff <= nxt_out_b;
            oe_a_n_ff <= nxt_oe_a_n;
            oe_b_n_ff <= nxt_oe_b_n;
            pef_a_n_ff <= nxt_pef_a_n;
            pef_b_n_ff <= nxt_pef_b_n;
        end
    end

    assign PORT_A_BUS_OUT = out_a_ff;
    assign PORT_B_BUS_OUT = out_b_ff;
    assign PORT_A_BUS_OE_N = oe_a_n_ff;
    assign PORT_B_BUS_OE_N = oe_b_n_ff;
    assign PORT_A_EMPTY_N = sync_ff[F_EMPTY_A][0];
    assign PORT_A_ALMOST_EMPTY_N = sync_ff[F_AEMPTY_A][0];
    assign PORT_A_FULL_N = sync_ff[F_FULL_A][0];
    assign PORT_A_ALMOST_FULL_N = sync_ff[F_AFULL_A][0];
    assign PORT_B_EMPTY_N = sync_ff[F_EMPTY_B][0];
    assign PORT_B_ALMOST_EMPTY_N = sync_ff[F_AEMPTY_B][0];
    assign PORT_B_FULL_N = sync_ff[F_FULL_B][0];
    assign PORT_B_ALMOST_FULL_N = sync_ff[F_AFULL_B][0];
    assign PORT_A_PARITY_ERROR_N = pef_a_n_ff;
    assign PORT_B_PARITY_ERROR_N = pef_b_n_ff;
    assign A_TO_B_MAILBOX_FREE = mfree_ab_ff;
    assign B_TO_A_MAILBOX_FREE = mfree_ba_ff;

    property p_gen_parity_a;
        @(posedge CORE_CLK) disable iff (RST)
        rd_ba && PORT_A_PARITY_GEN_SEL |=> byte_errors(qout_a_ff, $past(PARITY_ODD_SEL)) == '0;
    endproperty
    a_gen_parity_a: assert property (p_gen_parity_a)
        else $error("port A generated parity wrong");

    property p_raw_read_b;
        @(posedge CORE_CLK) disable iff (RST)
        rd_ab && !PORT_B_PARITY_GEN_SEL |=> qout_b_ff == $past(a_to_b_queue[rp_ab_ff]);
    endproperty
    a_raw_read_b: assert property (p_raw_read_b)
        else $error("port B output register not loaded from queue");

    property p_hold_qout_a;
        @(posedge CORE_CLK) disable iff (RST)
        !rd_ba |=> $stable(qout_a_ff);
    endproperty
    a_hold_qout_a: assert property (p_hold_qout_a)
        else $error("port A output register changed without a load");

    property p_mbox_gen_b;
        @(posedge CORE_CLK) disable iff (RST)
        mgen_b && CE && !mwr_ab |=> PORT_B_PARITY_ERROR_N && $stable(a_to_b_mailbox_ff)
            && byte_errors(out_b_ff, $past(PARITY_ODD_SEL)) == '0;
    endproperty
    a_mbox_gen_b: assert property (p_mbox_gen_b)
        else $error("port B mailbox parity generation wrong");

    property p_empty_b_rise;
        @(posedge CORE_CLK) disable iff (RST)
        wr_ab && cnt_ab_ff == CNT_RESET && !tick_b ##1 !tick_b
            ##1 tick_b ##1 !tick_b ##1 tick_b |=> PORT_B_EMPTY_N;
    endproperty
    a_empty_b_rise: assert property (p_empty_b_rise)
        else $error("port B empty flag late");

    property p_empty_a_rise;
        @(posedge CORE_CLK) disable iff (RST)
        wr_ba && cnt_ba_ff == CNT_RESET && !tick_a ##1 !tick_a
            ##1 tick_a ##1 !tick_a ##1 tick_a |=> PORT_A_EMPTY_N;
    endproperty
    a_empty_a_rise: assert property (p_empty_a_rise)
        else $error("port A empty flag late");

    property p_full_a_rise;
        @(posedge CORE_CLK) disable iff (RST)
        rd_ab && cnt_ab_ff == CNT_FULL && !tick_a ##1 (!tick_a) [*3]
            ##1 tick_a ##1 !tick_a ##1 tick_a |=> PORT_A_FULL_N;
    endproperty
    a_full_a_rise: assert property (p_full_a_rise)
        else $error("port A full flag late");

    property p_full_b_rise;
        @(posedge CORE_CLK) disable iff (RST)
        rd_ba && cnt_ba_ff == CNT_FULL && !tick_b ##1 (!tick_b) [*3]
            ##1 tick_b ##1 !tick_b ##1 tick_b |=> PORT_B_FULL_N;
    endproperty
    a_full_b_rise: assert property (p_full_b_rise)
        else $error("port B full flag late");

    property p_aempty_b_rise;
        @(posedge CORE_CLK) disable iff (RST)
        wr_ab && !rd_ab && cnt_ab_ff == X_CNT && !tick_b ##1 !tick_b
            ##1 (tick_b && !rd_ab) ##1 !tick_b ##1 (tick_b && !rd_ab) |=> PORT_B_ALMOST_EMPTY_N;
    endproperty
    a_aempty_b_rise: assert property (p_aempty_b_rise)
        else $error("port B almost-empty flag late");

    property p_aempty_two_ticks;
        @(posedge CORE_CLK) disable iff (RST)
        $rose(PORT_A_ALMOST_EMPTY_N) |-> $past(tick_a) && $past(cnt_ba_ff, 2) > X_CNT;
    endproperty
    a_aempty_two_ticks: assert property (p_aempty_two_ticks)
        else $error("port A almost-empty rose too early");

    property p_afull_a_rise;
        @(posedge CORE_CLK) disable iff (RST)
        rd_ab && !wr_ab && cnt_ab_ff == AF_CNT && !tick_a ##1 (!tick_a) [*3]
            ##1 (tick_a && !wr_ab) ##1 !tick_a ##1 (tick_a && !wr_ab) |=> PORT_A_ALMOST_FULL_N;
    endproperty
    a_afull_a_rise: assert property (p_afull_a_rise)
        else $error("port A almost-full flag late");

    c_queue_fill: cover property (@(posedge CORE_CLK) disable iff (RST) cnt_ab_ff == CNT_FULL);
    c_mbox_gen: cover property (@(posedge CORE_CLK) disable iff (RST) mgen_a && mrd_ba);
    c_gen_read: cover property (@(posedge CORE_CLK) disable iff (RST)
        rd_ab && PORT_B_PARITY_GEN_SEL && PARITY_ODD_SEL);
endmodule : bidir_fifo_port
`default_nettype wire

/* File: dv/port_host.sv */
// Purpose: behavioural bus controller for one port of the two-queue block
// Assumes: one operation per port tick, controls launched at the falling edge
// Notes: a line driven by neither side shows the inverse of the last drive so stale data never passes for fresh
`default_nettype none
module port_host
    import bfifo_pkg::*;
(
    input wire logic clk,
    input wire logic [bfifo_pkg::DATA_W-1:0] dev_out,
    input wire logic dev_oe_n,
    output logic tick,
    output logic cs_n,
    output logic wr,
    output logic mb,
    output logic en,
    output logic pg,
    output logic [bfifo_pkg::DATA_W-1:0] line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'h0;
    logic [DATA_W-1:0] dout = 36'h0;
    initial begin
        tick = 1'h0;
        cs_n = 1'h1;
        wr = 1'h0;
        mb = 1'h0;
        en = 1'h0;
        pg = 1'h0;
    end
    assign line = drv ? dout : (!dev_oe_n ? dev_out : ~dout);
    // k: 0 idle tick, 1 queue write, 2 queue read, 3 mail write, 4 mail read
    task automatic op(input int k, input logic [DATA_W-1:0] d, input logic g);
        @(negedge clk);
        tick = 1'h1;
        cs_n = (k == 0);
        wr = (k == 1) || (k == 3);
        mb = (k >= 3);
        en = 1'h1;
        pg = g;
        if (wr) begin
            dout = d;
        end
        drv = wr && !cs_n;
        @(negedge clk);
        tick = 1'h0;
        drv = 1'h0;
        // past the loading edge the select is free, so upset it on purpose
        if (k == 2) begin
            pg = ~g;
        end
    endtask : op
endmodule : port_host
`default_nettype wire

/* File: dv/bidir_fifo_parity_gen_flag_sync_bench.sv */
// Purpose: self-checking bench of queue parity generation, mailboxes and flag sync
// Assumes: default offset of eight words, ports ticked only by the host models
// Notes: queue contents are modelled with queues; parity worked out independently
`default_nettype none
module bidir_fifo_parity_gen_flag_sync_bench;
    import bfifo_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic odd = 1'h0;
    logic [31:0] seed = 32'h04fc3614;
    int miscompares = 0;
    int checks = 0;
    logic [DATA_W-1:0] qab[$];
    logic [DATA_W-1:0] qba[$];
    logic [DATA_W-1:0] a_out, b_out, a_line, b_line, w;
    logic a_oe_n, b_oe_n, a_e, a_ae, a_f, a_af, b_e, b_ae, b_f, b_af, a_pe, b_pe, ab_fr, ba_fr;
    logic a_tk, a_cs, a_wr, a_mb, a_en, a_pg, b_tk, b_cs, b_wr, b_mb, b_en, b_pg;
    wire logic [6:0] fl = {a_af, a_f, b_af, b_f, b_ae, a_e, b_e};
    port_host host_a (.clk(core_clk), .dev_out(a_out), .dev_oe_n(a_oe_n), .tick(a_tk),
        .cs_n(a_cs), .wr(a_wr), .mb(a_mb), .en(a_en), .pg(a_pg), .line(a_line));
    port_host host_b (.clk(core_clk), .dev_out(b_out), .dev_oe_n(b_oe_n), .tick(b_tk),
        .cs_n(b_cs), .wr(b_wr), .mb(b_mb), .en(b_en), .pg(b_pg), .line(b_line));
    bidir_fifo_port dut (.CORE_CLK(core_clk), .RST(rst), .CE(1'h1), .PORT_A_CLOCK(a_tk),
        .PORT_A_CHIP_SELECT_N(a_cs), .PORT_A_WRITE_READ_SEL(a_wr), .PORT_A_MAILBOX_SEL(a_mb),
        .PORT_A_ENABLE(a_en), .PORT_A_PARITY_GEN_SEL(a_pg), .PORT_A_BUS_IN(a_line),
        .PORT_A_BUS_OUT(a_out), .PORT_A_BUS_OE_N(a_oe_n), .PORT_B_CLOCK(b_tk),
        .PORT_B_CHIP_SELECT_N(b_cs), .PORT_B_WRITE_READ_SEL(b_wr), .PORT_B_MAILBOX_SEL(b_mb),
        .PORT_B_ENABLE(b_en), .PORT_B_PARITY_GEN_SEL(b_pg), .PORT_B_BUS_IN(b_line),
        .PORT_B_BUS_OUT(b_out), .PORT_B_BUS_OE_N(b_oe_n), .PARITY_ODD_SEL(odd),
        .PORT_A_EMPTY_N(a_e), .PORT_A_ALMOST_EMPTY_N(a_ae), .PORT_A_FULL_N(a_f),
        .PORT_A_ALMOST_FULL_N(a_af), .PORT_B_EMPTY_N(b_e), .PORT_B_ALMOST_EMPTY_N(b_ae),
        .PORT_B_FULL_N(b_f), .PORT_B_ALMOST_FULL_N(b_af), .PORT_A_PARITY_ERROR_N(a_pe),
        .PORT_B_PARITY_ERROR_N(b_pe), .A_TO_B_MAILBOX_FREE(ab_fr), .B_TO_A_MAILBOX_FREE(ba_fr));
    initial begin
        forever #4 core_clk = ~core_clk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [DATA_W-1:0] r36();
        logic [31:0] t;
        t = rnd();
        return {t[3:0], rnd()};
    endfunction : r36
    function automatic logic [DATA_W-1:0] gen(input logic [DATA_W-1:0] d, input logic o);
        for (int i = 0; i < BYTES; i++) begin
            d[i*BYTE_W+8] = (^d[i*BYTE_W +: 8]) ^ o;
        end
        return d;
    endfunction : gen
    task automatic chk(input string nm, input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tk(input int p, input int k, input logic [DATA_W-1:0] d, input logic g);
        if (p == 0) begin
            host_a.op(k, d, g);
        end else begin
            host_b.op(k, d, g);
        end
    endtask : tk
    // one synchronising tick is never enough, the second must raise the flag
    task automatic sync_chk(input int p, input int f, input string nm);
        tk(p, 0, 36'h0, 1'h0);
        chk(nm, fl[f], 36'h0);
        tk(p, 0, 36'h0, 1'h0);
        @(negedge core_clk);
        chk(nm, fl[f], 36'h1);
    endtask : sync_chk
    task automatic wr_q(input int p);
        logic [DATA_W-1:0] d;
        d = r36();
        tk(p, 1, d, 1'h0);
        if (p == 0) qab.push_back(d);
        else qba.push_back(d);
    endtask : wr_q
    task automatic rd_q(input int p);
        logic [31:0] t;
        logic [DATA_W-1:0] e;
        t = rnd();
        odd = t[1];
        tk(p, 2, 36'h0, t[0]);
        odd = ~t[1];
        e = (p == 0) ? qba.pop_front() : qab.pop_front();
        e = t[0] ? gen(e, t[1]) : e;
        repeat (2) @(negedge core_clk);
        chk("read word", (p == 0) ? a_out : b_out, e);
    endtask : rd_q
    task automatic give_verdict();
        if (miscompares == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : give_verdict
    initial begin
        repeat (5) @(negedge core_clk);
        rst = 1'h0;
        chk("reset", {a_e, a_ae, a_f, a_af, b_e, b_ae, b_f, b_af, a_oe_n, b_oe_n, a_pe, b_pe, ab_fr, ba_fr}, 36'h3f);
        repeat (3) tk(0, 0, 36'h0, 1'h0);
        repeat (3) tk(1, 0, 36'h0, 1'h0);
        wr_q(0);
        sync_chk(1, 0, "b empty");
        repeat (8) wr_q(0);
        sync_chk(1, 2, "b almost empty");
        wr_q(0);
        repeat (10) rd_q(1);
        chk("b drained", b_e, 36'h0);
        repeat (64) wr_q(0);
        chk("a full", a_f, 36'h0);
        repeat (2) tk(1, 0, 36'h0, 1'h0);
        rd_q(1);
        sync_chk(0, 5, "a full");
        repeat (8) rd_q(1);
        sync_chk(0, 6, "a almost full");
        wr_q(1);
        sync_chk(0, 1, "a empty");
        repeat (63) wr_q(1);
        tk(1, 1, r36(), 1'h0);
        chk("b full", b_f, 36'h0);
        rd_q(0);
        sync_chk(1, 3, "b full");
        repeat (8) rd_q(0);
        chk("a almost empty", a_ae, 36'h1);
        sync_chk(1, 4, "b almost full");
        repeat (55) rd_q(0);
        chk("a drained", a_e, 36'h0);
        odd = 1'h1;
        w = gen(r36(), 1'h1) ^ 36'h100;
        tk(0, 3, w, 1'h0);
        chk("mail free", ab_fr, 36'h0);
        chk("a parity", a_pe, 36'h0);
        tk(1, 4, 36'h0, 1'h1);
        repeat (4) @(negedge core_clk);
        chk("mail gen", b_out, gen(w, 1'h1));
        chk("mail gen flag", {b_pe, ab_fr}, 36'h3);
        tk(1, 4, 36'h0, 1'h0);
        repeat (4) @(negedge core_clk);
        chk("mail raw", b_out, w);
        chk("mail raw flag", b_pe, 36'h0);
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        give_verdict();
    end
endmodule : bidir_fifo_parity_gen_flag_sync_bench
`default_nettype wire
